// ===== logic/boot_pkg.sv
/*
 * Constants shared by the serial boot command engine: acknowledge codes,
 * command codes, RAM window and frame positions.
 * Assumes a byte-wide receive stream with a fault flag per byte.
 */
package boot_pkg;
	localparam logic [7:0]  ACK_UART      = 8'h86; // Mode echo, asynchronous
	localparam logic [7:0]  ACK_CLOCKED   = 8'h30; // Mode echo, clocked I/O
	localparam logic [7:0]  CMD_RAM_LOAD  = 8'h10; // RAM transfer command
	localparam logic [7:0]  CMD_ERASE     = 8'h40; // Chip erase command
	localparam logic [7:0]  CODE_ERASE_EN = 8'h54; // Erase enable code
	localparam logic [7:0]  ERASE_OK      = 8'h4F; // Erase finished
	localparam logic [7:0]  ERASE_FAIL    = 8'h4C; // Erase error
	localparam logic [3:0]  NIB_OK        = 4'h0;  // Low nibble, normal
	localparam logic [3:0]  NIB_BAD       = 4'h1;  // Low nibble, bit 0
	localparam logic [3:0]  NIB_RXERR     = 4'h8;  // Low nibble, bit 3
	localparam logic [31:0] RAM_LOW       = 32'h2000_0800; // First legal
	localparam logic [31:0] RAM_HIGH      = 32'h2000_FFFF; // Last RAM byte
	localparam logic [2:0]  HDR_LEN       = 3'h7;  // Header bytes with sum
	localparam int          FIFO_DEPTH    = 8;     // Receive FIFO words
	localparam logic [7:0]  SUM_ZERO      = 8'h00; // Sum that passes
endpackage : boot_pkg

// ===== logic/byte_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ns
module byte_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input  wire logic             clock_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH]; // Storage
	logic [AW-1:0]    wr_q;          // Write pointer
	logic [AW-1:0]    rd_q;          // Read pointer
	logic [AW:0]      cnt_q;         // Fill level
	logic             push;
	logic             pop;

	assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign out_valid_o = (cnt_q != '0);
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;
	assign out_data_o  = mem_q[rd_q];

	// Storage write; no reset needed for data
	always_ff @(posedge clock_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	// Pointers and level
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : byte_fifo

// ===== logic/boot_engine.sv
/*
 * Serial boot command engine: command byte, RAM load header and data,
 * chip erase sequence, acknowledge encoding.
 * Assumes a serial channel that delivers received bytes with a fault
 * flag, accepts transmit bytes on a valid/ready pair, and an erase
 * controller that answers a start pulse with done and error.
 */
`timescale 1ns/1ns
// How it works
// - Header receive fault answers 0x18, back to wait
// - Clocked mode ignores every receive fault
// - Header sum nonzero answers 0x11
// - Start address must be in RAM window
// - Good header answered 0x10 before data
// - Data bytes stored from start, count bytes
// - Data fault 0x18, bad sum 0x11, else 0x10
// - Jump to start only after 0x10 sent
// - Command 0x40 starts erase, echoed back
// - Command fault: previous nibble, low 8
// - Unknown command: previous nibble, low 1
// - Code 0x54 echoed, then erase runs
// - Bad enable code: low nibble 1, wait
// - Erase result 0x4F good, 0x4C bad
// - Ack upper nibble from command, bits 1,2 zero
// - Unusable baud: abandon, send nothing
// - Good sum low 0; password fail uses load nibble
// - After erase result, wait for a command
// - Mode echo 0x86 asynchronous, 0x30 clocked
module boot_engine (
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	input  wire logic        session_start_i, // Mode byte seen, pulse
	input  wire logic        clocked_mode_i,  // Clocked I/O mode
	input  wire logic        baud_ok_i,       // Rate can be programmed
	input  wire logic        password_ok_i,   // Password stage result
	input  wire logic [7:0]  rx_data_i,       // Received byte
	input  wire logic        rx_fault_i,      // Fault on that byte
	input  wire logic        rx_valid_i,      // Byte strobe
	output logic             rx_ready_o,      // FIFO has room
	output logic      [7:0]  tx_data_o,       // Byte to send
	output logic             tx_valid_o,      // Send request
	input  wire logic        tx_ready_i,      // Channel takes byte
	output logic      [31:0] ram_addr_o,      // RAM write address
	output logic      [7:0]  ram_data_o,      // RAM write data
	output logic             ram_we_o,        // RAM write pulse
	output logic             erase_start_o,   // Erase start pulse
	input  wire logic        erase_done_i,    // Erase finished pulse
	input  wire logic        erase_error_i,   // Erase error, with done
	output logic             jump_o,          // Branch pulse
	output logic      [31:0] jump_addr_o,     // Branch target
	output logic             aborted_o        // Session given up
);
	// Protocol states; S_SEND is shared by every reply
	typedef enum logic [3:0] {
		S_IDLE     = 4'b0000, // No session
		S_CMD      = 4'b0001, // Waiting for command byte
		S_PWD      = 4'b0010, // Password check, other block
		S_HDR      = 4'b0011, // Collecting header
		S_DATA     = 4'b0100, // Storing data
		S_DSUM     = 4'b0101, // Data checksum byte
		S_ENABLE   = 4'b0110, // Waiting erase enable code
		S_ERASE    = 4'b0111, // Erase running
		S_SEND     = 4'b1000  // Sending an acknowledge
	} state_t;

	// Registered protocol state
	state_t      state_q;     // Main state
	state_t      after_q;     // State after the send
	logic [3:0]  nib_q;       // Last accepted command nibble
	logic [7:0]  tx_q;        // Pending transmit byte
	logic        go_q;        // Branch after send
	logic        abort_q;     // Session abandoned
	logic [2:0]  hcnt_q;      // Header byte index
	logic [7:0]  sum_q;       // Running modulo-256 sum
	logic        fault_q;     // Fault seen in this block
	logic [31:0] start_q;     // Start address
	logic [15:0] count_q;     // Byte count
	logic [15:0] left_q;      // Bytes still to store
	logic [31:0] waddr_q;     // Next store address
	logic [7:0]  wdata_q;     // Store data
	logic        we_q;        // Store pulse
	logic        erase_q;     // Erase start pulse
	logic        jump_q;      // Branch pulse

	// Combinational helpers
	logic [7:0]  f_data;      // FIFO output byte
	logic        f_fault;     // FIFO output fault
	logic        f_valid;     // Byte ready to consume
	logic        f_take;      // Consume this cycle
	logic        fault;       // Fault after mode masking
	logic [7:0]  sum_next;    // Sum including this byte
	logic        last_hdr;    // Last header byte now
	logic [31:0] addr_next;   // Address with this byte

	// Bytes wait here while an acknowledge is going out
	byte_fifo #(
		.WIDTH (9),
		.DEPTH (boot_pkg::FIFO_DEPTH)
	) rx_fifo (
		.clock_i     (clock_i),
		.rst_n_i     (rst_n_i),
		.in_data_i   ({rx_fault_i, rx_data_i}),
		.in_valid_i  (rx_valid_i),
		.in_ready_o  (rx_ready_o),
		.out_data_o  ({f_fault, f_data}),
		.out_valid_o (f_valid),
		.out_ready_i (f_take)
	);

	// Only consume while listening; stalls fill the FIFO
	assign f_take = f_valid && (state_q == S_CMD || state_q == S_HDR ||
		state_q == S_DATA || state_q == S_DSUM || state_q == S_ENABLE);
	assign fault     = f_fault & ~clocked_mode_i;
	assign sum_next  = sum_q + f_data;
	assign last_hdr  = (hcnt_q == boot_pkg::HDR_LEN - 3'h1);
	assign addr_next = {start_q[23:0], f_data};

	// Data outputs come straight from flip-flops
	assign tx_data_o     = tx_q;
	assign tx_valid_o    = (state_q == S_SEND);
	assign ram_addr_o    = waddr_q;
	assign ram_data_o    = wdata_q;
	assign ram_we_o      = we_q;
	assign erase_start_o = erase_q;
	assign jump_o        = jump_q;
	assign jump_addr_o   = start_q;
	assign aborted_o     = abort_q;

	// Protocol sequencer
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			// Every register clears to a constant
			state_q <= S_IDLE;
			after_q <= S_IDLE;
			nib_q   <= 4'h0;
			tx_q    <= 8'h00;
			go_q    <= 1'b0;
			abort_q <= 1'b0;
			hcnt_q  <= 3'h0;
			sum_q   <= 8'h00;
			fault_q <= 1'b0;
			start_q <= 32'h0000_0000;
			count_q <= 16'h0000;
			left_q  <= 16'h0000;
			erase_q <= 1'b0;
			jump_q  <= 1'b0;
		end else begin
			// Pulses last one cycle unless set below
			erase_q <= 1'b0;
			jump_q  <= 1'b0;
			unique case (state_q)
				// Idle: wait for the mode byte verdict
				S_IDLE: begin
					if (session_start_i) begin
						// Unusable rate: stay silent, no reply
						if (!clocked_mode_i && !baud_ok_i) begin
							abort_q <= 1'b1;
						end else begin
							// Echo the mode, then wait for a command
							abort_q <= 1'b0;
							tx_q    <= clocked_mode_i ? boot_pkg::ACK_CLOCKED
								: boot_pkg::ACK_UART;
							after_q <= S_CMD;
							state_q <= S_SEND;
						end
					end
				end
				// Command byte decode
				S_CMD: begin
					if (f_take) begin
						state_q <= S_SEND;
						after_q <= S_CMD;
						// Fault wins over any decode
						if (fault) begin
							tx_q <= {nib_q, boot_pkg::NIB_RXERR};
						end else if (f_data == boot_pkg::CMD_RAM_LOAD) begin
							tx_q    <= f_data;
							nib_q   <= f_data[7:4];
							after_q <= S_PWD;
						end else if (f_data == boot_pkg::CMD_ERASE) begin
							tx_q    <= f_data;
							nib_q   <= f_data[7:4];
							after_q <= S_ENABLE;
						end else begin
							// Unknown code keeps the old nibble
							tx_q <= {nib_q, boot_pkg::NIB_BAD};
						end
					end
				end
				// Password verdict from the outside stage
				S_PWD: begin
					// Password bytes are handled elsewhere; only its verdict
					hcnt_q  <= 3'h0;
					sum_q   <= 8'h00;
					fault_q <= 1'b0;
					// Verdict is read one cycle after the echo
					if (!password_ok_i) begin
						tx_q    <= {boot_pkg::CMD_RAM_LOAD[7:4],
							boot_pkg::NIB_BAD};
						after_q <= S_CMD;
						state_q <= S_SEND;
					end else begin
						state_q <= S_HDR;
					end
				end
				// Seven header bytes, sum included
				S_HDR: begin
					if (f_take) begin
						sum_q   <= sum_next;
						fault_q <= fault_q | fault;
						hcnt_q  <= hcnt_q + 3'h1;
						// Bytes 0-3 address, 4-5 count, 6 sum
						if (hcnt_q < 3'h4) begin
							start_q <= addr_next;
						end else if (hcnt_q < 3'h6) begin
							count_q <= {count_q[7:0], f_data};
						end
						// Seventh byte decides the reply
						if (last_hdr) begin
							state_q <= S_SEND;
							after_q <= S_CMD;
							sum_q   <= 8'h00;
							fault_q <= 1'b0;
							left_q  <= count_q;
							// Fault first, then sum and window
							if (fault_q | fault) begin
								tx_q <= {nib_q, boot_pkg::NIB_RXERR};
							end else if (sum_next != boot_pkg::SUM_ZERO ||
								start_q < boot_pkg::RAM_LOW ||
								start_q > boot_pkg::RAM_HIGH) begin
								tx_q <= {nib_q, boot_pkg::NIB_BAD};
							end else begin
								tx_q    <= {nib_q, boot_pkg::NIB_OK};
								after_q <= (count_q == 16'h0000) ? S_DSUM : S_DATA;
							end
						end
					end
				end
				// Counted data bytes go to RAM
				S_DATA: begin
					if (f_take) begin
						sum_q   <= sum_next;
						fault_q <= fault_q | fault;
						left_q  <= left_q - 16'h0001;
						// Last counted byte; the sum follows
						if (left_q == 16'h0001) begin
							state_q <= S_DSUM;
						end
					end
				end
				// Data checksum decides the branch
				S_DSUM: begin
					// Checksum byte is the sum's two's complement
					if (f_take) begin
						state_q <= S_SEND;
						after_q <= S_CMD;
						go_q    <= 1'b0;
						// Only a clean block arms the branch
						if (fault_q | fault) begin
							tx_q <= {nib_q, boot_pkg::NIB_RXERR};
						end else if (sum_next != boot_pkg::SUM_ZERO) begin
							tx_q <= {nib_q, boot_pkg::NIB_BAD};
						end else begin
							tx_q    <= {nib_q, boot_pkg::NIB_OK};
							go_q    <= 1'b1;
							after_q <= S_IDLE;
						end
					end
				end
				// Erase enable code
				S_ENABLE: begin
					if (f_take) begin
						state_q <= S_SEND;
						after_q <= S_CMD;
						// A fault here keeps the erase nibble
						if (fault) begin
							tx_q <= {nib_q, boot_pkg::NIB_RXERR};
						end else if (f_data == boot_pkg::CODE_ERASE_EN) begin
							tx_q    <= f_data;
							after_q <= S_ERASE;
						end else begin
							tx_q <= {nib_q, boot_pkg::NIB_BAD};
						end
					end
				end
				// Erase running outside this block
				S_ERASE: begin
					// Error is read with done, same cycle
					if (erase_done_i) begin
						tx_q    <= erase_error_i ? boot_pkg::ERASE_FAIL
							: boot_pkg::ERASE_OK;
						after_q <= S_CMD;
						state_q <= S_SEND;
					end
				end
				// Hold the reply until the channel takes it
				S_SEND: begin
					if (tx_ready_i) begin
						// Byte taken; move on and fire pulses
						state_q <= after_q;
						if (after_q == S_ERASE) begin
							erase_q <= 1'b1;
						end
						if (go_q) begin
							jump_q <= 1'b1;
							go_q   <= 1'b0;
						end
					end
				end
				// Unused codes fall back to idle
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// RAM store path; address steps one byte per stored word
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			waddr_q <= 32'h0000_0000;
			wdata_q <= 8'h00;
			we_q    <= 1'b0;
		end else begin
			// Write pulse is one cycle per byte
			we_q <= 1'b0;
			// Address reloads while the header arrives
			if (state_q == S_HDR) begin
				waddr_q <= start_q;
			end else if (state_q == S_SEND && after_q == S_DATA) begin
				waddr_q <= start_q;
			end else if (state_q == S_DATA && f_take) begin
				wdata_q <= f_data;
				we_q    <= 1'b1;
				// Step after a store, never before the first
				if (we_q) begin
					waddr_q <= waddr_q + 32'h0000_0001;
				end
			end else if (we_q) begin
				waddr_q <= waddr_q + 32'h0000_0001;
			end
		end
	end
endmodule : boot_engine

// ===== tb/boot_engine_chk.sv
/* Port assertions for the boot engine.
   Assumes binding to boot_engine; one clock, async active-low reset. */
`timescale 1ns/1ns
module boot_engine_chk (
	input wire logic        clock_i,
	input wire logic        rst_n_i,
	input wire logic        session_start_i,
	input wire logic        clocked_mode_i,
	input wire logic        baud_ok_i,
	input wire logic [7:0]  tx_data_o,
	input wire logic        tx_valid_o,
	input wire logic        tx_ready_i,
	input wire logic [31:0] ram_addr_o,
	input wire logic        ram_we_o,
	input wire logic        erase_start_o,
	input wire logic        erase_done_i,
	input wire logic        erase_error_i,
	input wire logic        jump_o,
	input wire logic        aborted_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	ack_bits_a: assert property (
		tx_valid_o && tx_data_o[7:4] == 4'h1 |-> tx_data_o[2:1] == 2'h0)
		else $error("ack carries bit 1 or 2");
	tx_hold_a: assert property (
		tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
		else $error("ack dropped before taken");
	clk_echo_a: assert property (
		session_start_i && clocked_mode_i |-> ##[1:2]
		tx_valid_o && tx_data_o == boot_pkg::ACK_CLOCKED)
		else $error("clocked mode echo missing");
	uart_echo_a: assert property (
		session_start_i && !clocked_mode_i && baud_ok_i |-> ##[1:2]
		tx_valid_o && tx_data_o == boot_pkg::ACK_UART)
		else $error("uart mode echo missing");
	abort_quiet_a: assert property (aborted_o |-> !tx_valid_o)
		else $error("byte sent after abort");
	jump_late_a: assert property (jump_o |->
		$past(tx_valid_o && tx_ready_i && tx_data_o == 8'h10) ||
		$past(tx_valid_o && tx_ready_i && tx_data_o == 8'h10, 2))
		else $error("jump without normal ack");
	erase_go_a: assert property (erase_start_o |->
		$past(tx_valid_o && tx_ready_i && tx_data_o == 8'h54) ||
		$past(tx_valid_o && tx_ready_i && tx_data_o == 8'h54, 2))
		else $error("erase before enable echo");
	erase_ok_a: assert property (
		erase_done_i && !erase_error_i |-> ##[1:3]
		tx_valid_o && tx_data_o == boot_pkg::ERASE_OK)
		else $error("erase success code missing");
	erase_bad_a: assert property (
		erase_done_i && erase_error_i |-> ##[1:3]
		tx_valid_o && tx_data_o == boot_pkg::ERASE_FAIL)
		else $error("erase error code missing");
	ram_win_a: assert property (ram_we_o |->
		ram_addr_o >= boot_pkg::RAM_LOW && ram_addr_o <= boot_pkg::RAM_HIGH)
		else $error("RAM write outside window");
endmodule : boot_engine_chk

bind boot_engine boot_engine_chk chk (
	.clock_i(clock_i),
	.rst_n_i(rst_n_i),
	.session_start_i(session_start_i),
	.clocked_mode_i(clocked_mode_i),
	.baud_ok_i(baud_ok_i),
	.tx_data_o(tx_data_o),
	.tx_valid_o(tx_valid_o),
	.tx_ready_i(tx_ready_i),
	.ram_addr_o(ram_addr_o),
	.ram_we_o(ram_we_o),
	.erase_start_o(erase_start_o),
	.erase_done_i(erase_done_i),
	.erase_error_i(erase_error_i),
	.jump_o(jump_o),
	.aborted_o(aborted_o)
);

// ===== tb/boot_host.sv
/* Programming controller model on the serial side.
   Assumes the bench queues bytes with put and reads acks from got. */
`timescale 1ns/1ns
module boot_host (
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	input  wire logic       stall_i,
	input  wire logic       rx_ready_i,
	output logic      [7:0] rx_data_o,
	output logic            rx_fault_o,
	output logic            rx_valid_o,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_valid_i,
	output logic            tx_ready_o
);
	logic [8:0] sq[$];  // Bytes to send, fault flag on top
	logic [7:0] got[$]; // Acks taken
	logic [1:0] pace_q; // Ready skips one cycle in four
	task automatic put(input logic [7:0] d, input logic f);
		sq.push_back({f, d});
	endtask : put
	// Offer bytes; idle line shows no stale value
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sq.delete();
			rx_valid_o <= 1'b0;
			rx_data_o  <= 8'h00;
			rx_fault_o <= 1'b0;
		end else if (!rx_valid_o || rx_ready_i) begin
			if (sq.size() != 0) begin
				{rx_fault_o, rx_data_o} <= sq.pop_front();
				rx_valid_o <= 1'b1;
			end else begin
				rx_valid_o <= 1'b0;
				rx_data_o  <= ~rx_data_o;
				rx_fault_o <= ~rx_fault_o;
			end
		end
	end
	// Take acks, sometimes late, never while stalled
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			got.delete();
			pace_q     <= 2'h0;
			tx_ready_o <= 1'b0;
		end else begin
			pace_q     <= pace_q + 2'h1;
			tx_ready_o <= !stall_i && pace_q != 2'h0;
			if (tx_valid_i && tx_ready_o)
				got.push_back(tx_data_i);
		end
	end
endmodule : boot_host

// ===== tb/boot_engine_tb.sv
/* Bench for the boot engine: abort, load, faults, erase, clocked mode.
   Assumes boot_host on the serial side and an erase stand-in here. */
`timescale 1ns/1ns
module boot_engine_tb;
	logic        clock_i, rst_n_i, session_start_i, clocked_mode_i;
	logic        baud_ok_i, password_ok_i, rx_fault_i, rx_valid_i;
	logic        rx_ready_o, tx_valid_o, tx_ready_i, ram_we_o, jump_o;
	logic        erase_start_o, erase_done_i, erase_error_i, aborted_o;
	logic        stall;
	logic [1:0]  ecnt = 2'h0;
	logic [7:0]  rx_data_i, tx_data_o, ram_data_o;
	logic [31:0] ram_addr_o, jump_addr_o, jump_seen;
	logic [31:0] wa[$];
	logic [7:0]  wd[$];
	int          bad_count, comparisons;
	boot_engine DUT (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.session_start_i(session_start_i), .clocked_mode_i(clocked_mode_i),
		.baud_ok_i(baud_ok_i), .password_ok_i(password_ok_i),
		.rx_data_i(rx_data_i), .rx_fault_i(rx_fault_i),
		.rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
		.tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
		.tx_ready_i(tx_ready_i), .ram_addr_o(ram_addr_o),
		.ram_data_o(ram_data_o), .ram_we_o(ram_we_o),
		.erase_start_o(erase_start_o), .erase_done_i(erase_done_i),
		.erase_error_i(erase_error_i), .jump_o(jump_o),
		.jump_addr_o(jump_addr_o), .aborted_o(aborted_o));
	boot_host host (.clock_i(clock_i), .rst_n_i(rst_n_i), .stall_i(stall),
		.rx_ready_i(rx_ready_o), .rx_data_o(rx_data_i),
		.rx_fault_o(rx_fault_i), .rx_valid_o(rx_valid_i),
		.tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
		.tx_ready_o(tx_ready_i));
	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	// Erase stand-in and RAM/jump monitor
	always @(posedge clock_i) begin
		erase_done_i <= 1'b0;
		if (erase_start_o === 1'b1)
			ecnt <= 2'h3;
		else if (ecnt != 2'h0) begin
			ecnt         <= ecnt - 2'h1;
			erase_done_i <= ecnt == 2'h1;
		end
		if (ram_we_o === 1'b1) begin
			wa.push_back(ram_addr_o);
			wd.push_back(ram_data_o);
		end
		if (jump_o === 1'b1)
			jump_seen <= jump_addr_o;
	end
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic ex(input logic [7:0] e);
		int n;
		n = 0;
		while (host.got.size() == 0 && n < 3000) begin
			@(posedge clock_i);
			n++;
		end
		if (host.got.size() == 0)
			check("ack byte", 32'hFFFF_FFFF, e);
		else
			check("ack byte", {24'h0, host.got.pop_front()}, e);
	endtask : ex
	task automatic cmd(input logic [7:0] b, input logic f,
		input logic [7:0] e);
		host.put(b, f);
		ex(e);
	endtask : cmd
	task automatic rst;
		rst_n_i <= 1'b0;
		repeat (16) @(posedge clock_i);
		wa.delete();
		wd.delete();
		jump_seen <= 32'h0;
		rst_n_i   <= 1'b1;
	endtask : rst
	task automatic start(input logic c, input logic b);
		clocked_mode_i  <= c;
		baud_ok_i       <= b;
		session_start_i <= 1'b1;
		@(posedge clock_i);
		session_start_i <= 1'b0;
	endtask : start
	task automatic hdr(input logic [31:0] a, input logic [15:0] n,
		input logic [7:0] adj, input logic f);
		logic [7:0] b[6];
		logic [7:0] s;
		b = '{a[31:24], a[23:16], a[15:8], a[7:0], n[15:8], n[7:0]};
		s = adj;
		foreach (b[i]) begin
			host.put(b[i], f && i == 2);
			s = s - b[i];
		end
		host.put(s, 1'b0);
	endtask : hdr
	task automatic dat(input int n, input logic [7:0] adj, input logic f);
		logic [7:0] s;
		s = adj;
		for (int i = 0; i < n; i++) begin
			host.put(8'hA0 + i[7:0], f && i == 0);
			s = s - 8'hA0 - i[7:0];
		end
		host.put(s, 1'b0);
	endtask : dat
	task automatic t_abort;
		rst();
		start(1'b0, 1'b0);
		repeat (20) @(posedge clock_i);
		check("aborted", aborted_o, 32'h1);
		check("acks sent", host.got.size(), 32'h0);
		$display("test abort done");
	endtask : t_abort
	task automatic t_load;
		rst();
		start(1'b0, 1'b1);
		ex(boot_pkg::ACK_UART);
		stall <= 1'b1;
		host.put(boot_pkg::CMD_RAM_LOAD, 1'b0);
		hdr(32'h2000_0800, 16'h0003, 8'h00, 1'b0);
		dat(3, 8'h00, 1'b0);
		repeat (40) @(posedge clock_i);
		check("fifo ready", rx_ready_o, 32'h0);
		stall <= 1'b0;
		ex(8'h10);
		ex(8'h10);
		ex(8'h10);
		repeat (8) @(posedge clock_i);
		check("jump target", jump_seen, 32'h2000_0800);
		check("ram writes", wa.size(), 32'h3);
		foreach (wa[i]) begin
			check("ram addr", wa[i], 32'h2000_0800 + i);
			check("ram data", wd[i], 32'hA0 + i);
		end
		$display("test load done");
	endtask : t_load
	task automatic t_hdr;
		rst();
		start(1'b0, 1'b1);
		ex(boot_pkg::ACK_UART);
		cmd(8'h10, 1'b0, 8'h10);
		hdr(32'h2000_0800, 16'h0001, 8'h01, 1'b0);
		ex(8'h11);
		cmd(8'h10, 1'b0, 8'h10);
		hdr(32'h2000_0800, 16'h0001, 8'h00, 1'b1);
		ex(8'h18);
		cmd(8'h10, 1'b0, 8'h10);
		hdr(32'h2000_07FE, 16'h0001, 8'h00, 1'b0);
		ex(8'h11);
		cmd(8'h17, 1'b0, 8'h11);
		cmd(8'h40, 1'b1, 8'h18);
		// Password verdict comes before any header byte
		password_ok_i <= 1'b0;
		cmd(8'h10, 1'b0, 8'h10);
		ex(8'h11);
		password_ok_i <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			cmd(8'h10, 1'b0, 8'h10);
			hdr(32'h2000_0900, 16'h0002, 8'h00, 1'b0);
			ex(8'h10);
			dat(2, k[7:0], k == 0);
			ex(k == 0 ? 8'h18 : 8'h11);
		end
		check("jump", jump_seen, 32'h0);
		$display("test header faults done");
	endtask : t_hdr
	task automatic t_erase;
		rst();
		start(1'b0, 1'b1);
		ex(boot_pkg::ACK_UART);
		for (int k = 0; k < 2; k++) begin
			erase_error_i <= k == 1;
			cmd(8'h40, 1'b0, 8'h40);
			cmd(8'h54, 1'b0, 8'h54);
			ex(k == 0 ? 8'h4F : 8'h4C);
		end
		cmd(8'h40, 1'b0, 8'h40);
		cmd(8'h55, 1'b0, 8'h41);
		$display("test erase done");
	endtask : t_erase
	task automatic t_clk;
		rst();
		start(1'b1, 1'b1);
		ex(boot_pkg::ACK_CLOCKED);
		cmd(8'h10, 1'b1, 8'h10);
		hdr(32'h2000_0800, 16'h0001, 8'h00, 1'b1);
		ex(8'h10);
		dat(1, 8'h00, 1'b1);
		ex(8'h10);
		$display("test clocked mode done");
	endtask : t_clk
	task automatic complete_run;
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	initial begin
		repeat (60000) @(posedge clock_i);
		bad_count++;
		complete_run();
	end
	initial begin
		{rst_n_i, session_start_i, clocked_mode_i, stall} = 4'h0;
		{baud_ok_i, password_ok_i, erase_error_i} = 3'h6;
		{bad_count, comparisons} = '0;
		t_abort();
		t_load();
		t_hdr();
		t_erase();
		t_clk();
		complete_run();
	end
endmodule : boot_engine_tb
